// >>> adc_cfg_pkg.sv
`default_nettype none
package adc_cfg_pkg;

   // ==========================================================
   // register addresses
   localparam logic [3:0] ADDR_SETUP = 4'h0;
   localparam logic [3:0] ADDR_MUX   = 4'h1;
   localparam logic [3:0] ADDR_ACR   = 4'h2;
   localparam logic [3:0] ADDR_FIRST_CURRENT_SOURCE = 4'h3;
   localparam logic [3:0] ADDR_SECOND_CURRENT_SOURCE = 4'h4;
   localparam logic [3:0] ADDR_OFFSET_DAC_SETTING  = 4'h5;
   localparam logic [3:0] ADDR_DIO   = 4'h6;
   localparam logic [3:0] ADDR_DIR   = 4'h7;
   localparam logic [3:0] ADDR_RATE_DIVIDER_LOW  = 4'h8;
   localparam logic [3:0] ADDR_MDEC1 = 4'h9;

   // ==========================================================
   // field positions
   localparam int SETUP_SPEED  = 4;
   localparam int SETUP_REF_EN = 3;
   localparam int SETUP_HIGH_REFERENCE_SELECT = 2;
   localparam int SETUP_BUF_EN = 1;
   localparam int ACR_BOCS     = 7;
   localparam int MDEC1_FLAG   = 7;
   localparam int OFFSET_DAC_SETTING_SIGN    = 7;

   // ==========================================================
   // reset values
   localparam logic [7:0] SETUP_RESET = 8'h00;
   localparam logic [7:0] MUX_RESET   = 8'h01;
   localparam logic [7:0] ZERO_RESET  = 8'h00;
   localparam logic [7:0] DIR_RESET   = 8'h00;
   localparam logic [7:0] RATE_DIVIDER_LOW_RESET  = 8'h80;
   localparam logic [7:0] MDEC1_RESET = 8'h01;
   localparam logic [2:0] ID_CODE     = 3'h2; // arbitrary value

   // ==========================================================
   // codes and counts
   localparam logic [7:0]  MUX_TEMP_DIODE = 8'hff;
   localparam logic [7:0]  MOD_LAST_FAST  = 8'h7f; // divide by 128
   localparam logic [7:0]  MOD_LAST_SLOW  = 8'hff; // divide by 256
   localparam int          MOD_MSB_FAST   = 6;
   localparam int          MOD_MSB_SLOW   = 7;
   localparam logic [3:0]  CAL_ONE_PERIODS = 4'h7;
   localparam logic [3:0]  CAL_TWO_PERIODS = 4'he;
   localparam logic [10:0] DEC_ONE        = 11'h001;
   localparam logic [1:0]  SMODE_AUTO     = 2'h0;
   localparam logic [1:0]  SMODE_FAST     = 2'h1;
   localparam logic [1:0]  SMODE_SINC2    = 2'h2;

   typedef enum logic [2:0] {
      CAL_SELF_OFS, CAL_SELF_GAIN, CAL_SELF_BOTH, CAL_SYS_OFS, CAL_SYS_GAIN
   } cal_kind_t;

   typedef enum logic [1:0] {FILT_FAST, FILT_SINC2, FILT_SINC3} filter_t;

   typedef enum logic {PH_RUN, PH_CAL} phase_t;

   // input routing controls
   typedef struct packed {
      logic [3:0] pos_sel;
      logic [3:0] neg_sel;
      logic       ext_connect;
      logic       diode_connect;
      logic       first_current_source_to_diode;
      logic       burnout_source;
      logic       burnout_sink;
      logic       buffer_on;
   } route_t;

   // current sources, gain and offset
   typedef struct packed {
      logic [7:0] first_current_source_code;
      logic [1:0] first_current_source_range;
      logic [7:0] second_current_source_code;
      logic [1:0] second_current_source_range;
      logic [2:0] gain_code;
      logic       offset_dac_setting_negative;
      logic [6:0] offset_dac_setting_magnitude;
   } source_t;

endpackage
`default_nettype wire

// >>> adc_channel_config_control.sv
// Functional notes
// R01 - any channel may be positive input, any other negative input
// R02 - mux all ones routes temperature diode, anode positive, cathode negative
// R03 - temperature diode selection disconnects every external channel
// R04 - diode mode: first current source biases anode, stays on its pin
// R05 - burnout bit enables source on positive, sink on negative input
// R06 - input buffer on only when pin and control bit both high
// R07 - two current sources, each with 8-bit code and range bits
// R08 - gain code picks 1, 2, 4, 8, 16, 32, 64 or 128
// R09 - offset setting is sign-magnitude: top bit sign, seven bits size
// R10 - modulator clock is oscillator divided by 128 or 256 by speed
// R11 - reference enable bit switches reference, level bit picks 1.25/2.5V
// R12 - self offset or gain takes 7 periods, combined self takes 14
// R13 - system calibration uses host-applied input, done in 7 periods
// R14 - host calibrates after power-on, decimation or gain change
// R15 - host prefers system gain calibration at gain 8 or above
// R16 - ready flag goes low when any calibration finishes
// R17 - filter fast, sinc2, sinc3, or auto stepping after channel change
// R18 - host uses decimation multiple of four with fast filter
// R19 - all eight digital pins are inputs after power-up
// R20 - pin direction per bit; outputs drive their level register bit
// R21 - reading level register returns pin state for input pins
// R22 - host sets unused pins as outputs or grounded inputs
// R23 - ready flag low on new result, high again once read
`timescale 1ns/1ps
`default_nettype none
module adc_channel_config_control
   import adc_cfg_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output var  logic [7:0] reg_rdata,
   input  wire logic       cal_start,
   input  wire cal_kind_t  cal_kind,
   input  wire logic       data_read,
   input  wire logic       buffer_enable_pin,
   input  wire logic [7:0] dio_in,
   output var  logic [7:0] dio_out,
   output var  logic [7:0] dio_oe,
   output var  logic       conversion_ready_flag_n,
   output var  logic       cal_busy,
   output var  logic       mod_clk,
   output var  logic       conv_strobe,
   output var  filter_t    filter_sel,
   output var  route_t     route,
   output var  source_t    source,
   output var  logic       ref_on,
   output var  logic       high_reference_select
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0]  setup;
      logic [7:0]  mux;
      logic [7:0]  analog_control_register;
      logic [7:0]  first_current_source;
      logic [7:0]  second_current_source;
      logic [7:0]  offset_dac_setting;
      logic [7:0]  pin_level_register;
      logic [7:0]  pin_output_select;
      logic [7:0]  rate_divider_low;
      logic [7:0]  filter_mode_rate_high;
      logic [7:0]  rdata;
      logic [7:0]  mod_cnt;
      logic        mod_clk;
      logic [10:0] dec_cnt;
      phase_t      phase;
      logic [3:0]  cal_cnt;
      logic [3:0]  cal_target;
      logic        ready_n;
      logic        strobe;
      filter_t     auto_stage;
      filter_t     filter;
      route_t      route;
      source_t     source;
      logic        ref_on;
      logic        ref_high;
   } state_t;

   state_t      s_reg;
   state_t      s_next;
   logic        mod_tick;
   logic        conv_done;
   logic [7:0]  mod_last;
   logic [10:0] dec_ratio;
   logic [7:0]  pin_view;
   logic        sel_change;

   // helper terms, rebuilt every cycle
   // mod_tick: last count of a modulator period
   // conv_done: last tick of one data period
   // pin_view: what a level register read returns
   // sel_change: channel or gain write that differs
   // read data kept apart from register images


   // ==========================================================
   // next state
   always_comb begin
      s_next = s_reg;
      s_next.strobe = 1'b0;
      sel_change = 1'b0;

      // defaults keep every path assigned;
      // strobe is a one-cycle pulse, dropped here

      // modulator clock divider
      // R10 - divide select
      mod_last = s_reg.setup[SETUP_SPEED] ? MOD_LAST_SLOW : MOD_LAST_FAST;
      mod_tick = (s_reg.mod_cnt >= mod_last);
      if (mod_tick) begin
         s_next.mod_cnt = '0;
      end else begin
         s_next.mod_cnt = s_reg.mod_cnt + 8'h01;
      end
      s_next.mod_clk = s_reg.setup[SETUP_SPEED]
                       ? s_next.mod_cnt[MOD_MSB_SLOW]
                       : s_next.mod_cnt[MOD_MSB_FAST];


      // speed change lets the count run to the new limit;
      // the >= compare stops overshoot from slow to fast

      // decimation counter: one data period per ratio of ticks
      dec_ratio = {s_reg.filter_mode_rate_high[2:0], s_reg.rate_divider_low};
      if (dec_ratio == '0) begin
         dec_ratio = DEC_ONE; // guard against a zero ratio
      end
      conv_done = mod_tick && (s_reg.dec_cnt >= dec_ratio - DEC_ONE);
      if (mod_tick) begin
         s_next.dec_cnt = conv_done ? '0 : s_reg.dec_cnt + DEC_ONE;
      end


      // read clear sits before the period end on purpose:
      // a result in the same cycle wins and keeps it low
      // during calibration only the last period lowers it

      // result read releases the ready flag
      // R23 - read clears flag
      if (data_read) begin
         s_next.ready_n = 1'b1;
      end

      // end of a data period
      if (conv_done) begin
         if (s_reg.phase == PH_CAL) begin
            // R12 - count calibration periods
            // R13 - system cal period count
            s_next.cal_cnt = s_reg.cal_cnt + 4'h1;
            if (s_next.cal_cnt == s_reg.cal_target) begin
               s_next.phase = PH_RUN;
               // R16 - flag low at cal end
               s_next.ready_n = 1'b0;
            end
         end else begin
            // R23 - new result, set wins
            s_next.ready_n = 1'b0;
            s_next.strobe = 1'b1;
            // R17 - auto filter stepping
            unique case (s_reg.auto_stage)
               FILT_FAST:  s_next.auto_stage = FILT_SINC2;
               FILT_SINC2: s_next.auto_stage = FILT_SINC3;
               FILT_SINC3: s_next.auto_stage = FILT_SINC3;
            endcase
         end
      end


      // a start mid calibration restarts the count;
      // flag stays high until the last period ends

      // calibration start restarts the data period
      if (cal_start) begin
         s_next.phase = PH_CAL;
         s_next.cal_cnt = '0;
         s_next.dec_cnt = '0;
         s_next.ready_n = 1'b1;
         // R12 - combined takes 14
         s_next.cal_target = (cal_kind == CAL_SELF_BOTH) ? CAL_TWO_PERIODS
                                                        : CAL_ONE_PERIODS;
      end


      // writes land one cycle after the strobe edge;
      // unmapped addresses fall to the default

      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_SETUP: s_next.setup = reg_wdata;
            ADDR_MUX: begin
               s_next.mux = reg_wdata;
               sel_change = (reg_wdata != s_reg.mux);
            end
            ADDR_ACR: begin
               s_next.analog_control_register = reg_wdata;
               sel_change = (reg_wdata[2:0]
                             != s_reg.analog_control_register[2:0]);
            end
            ADDR_FIRST_CURRENT_SOURCE: s_next.first_current_source = reg_wdata;
            ADDR_SECOND_CURRENT_SOURCE: s_next.second_current_source = reg_wdata;
            ADDR_OFFSET_DAC_SETTING:  s_next.offset_dac_setting = reg_wdata;
            ADDR_DIO:   s_next.pin_level_register = reg_wdata;
            ADDR_DIR:   s_next.pin_output_select = reg_wdata;
            ADDR_RATE_DIVIDER_LOW:  s_next.rate_divider_low = reg_wdata;
            ADDR_MDEC1: s_next.filter_mode_rate_high = reg_wdata;
            default: ;
         endcase
      end
      // R17 - restart auto sequence
      if (sel_change) begin
         s_next.auto_stage = FILT_FAST;
      end


      // read data is registered, held to the next read;
      // output pins read back their own level bit

      // register reads, answered one cycle later
      // R21 - input pins read live
      pin_view = (s_reg.pin_output_select & s_reg.pin_level_register)
               | (~s_reg.pin_output_select & dio_in);
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_SETUP: s_next.rdata = {ID_CODE, s_reg.setup[4:0]};
            ADDR_MUX:   s_next.rdata = s_reg.mux;
            ADDR_ACR:   s_next.rdata = s_reg.analog_control_register;
            ADDR_FIRST_CURRENT_SOURCE: s_next.rdata = s_reg.first_current_source;
            ADDR_SECOND_CURRENT_SOURCE: s_next.rdata = s_reg.second_current_source;
            ADDR_OFFSET_DAC_SETTING:  s_next.rdata = s_reg.offset_dac_setting;
            ADDR_DIO:   s_next.rdata = pin_view;
            ADDR_DIR:   s_next.rdata = s_reg.pin_output_select;
            ADDR_RATE_DIVIDER_LOW:  s_next.rdata = s_reg.rate_divider_low;
            ADDR_MDEC1: begin
               s_next.rdata = s_reg.filter_mode_rate_high & 8'h77;
               s_next.rdata[MDEC1_FLAG] = s_reg.ready_n;
            end
            default:    s_next.rdata = 8'h00;
         endcase
      end


      // outputs use the next state, so each output
      // flop shows a new setting one cycle after a write

      // filter selection
      // R17 - filter select
      unique case (s_next.filter_mode_rate_high[5:4])
         SMODE_AUTO:  s_next.filter = s_next.auto_stage;
         SMODE_FAST:  s_next.filter = FILT_FAST;
         SMODE_SINC2: s_next.filter = FILT_SINC2;
         default:     s_next.filter = FILT_SINC3;
      endcase


      // all ones on the selector is kept for the diode

      // input routing
      // R01 - free channel pairing
      s_next.route.pos_sel = s_next.mux[7:4];
      s_next.route.neg_sel = s_next.mux[3:0];
      // R02 - diode on all ones
      s_next.route.diode_connect = (s_next.mux == MUX_TEMP_DIODE);
      // R03 - channels open
      s_next.route.ext_connect = (s_next.mux != MUX_TEMP_DIODE);
      // R04 - first source biases diode
      s_next.route.first_current_source_to_diode = (s_next.mux == MUX_TEMP_DIODE);
      // R05 - burnout pair
      s_next.route.burnout_source =
         s_next.analog_control_register[ACR_BOCS];
      s_next.route.burnout_sink =
         s_next.analog_control_register[ACR_BOCS];
      // R06 - pin and bit
      s_next.route.buffer_on =
         buffer_enable_pin & s_next.setup[SETUP_BUF_EN];


      // range and gain fields pass through as is;
      // the analog side decodes them

      // current sources, gain and offset
      // R07 - two current sources
      s_next.source.first_current_source_code = s_next.first_current_source;
      s_next.source.first_current_source_range = s_next.analog_control_register[4:3];
      s_next.source.second_current_source_code = s_next.second_current_source;
      s_next.source.second_current_source_range = s_next.analog_control_register[6:5];
      // R08 - gain code
      s_next.source.gain_code = s_next.analog_control_register[2:0];
      // R09 - sign and magnitude
      s_next.source.offset_dac_setting_negative = s_next.offset_dac_setting[OFFSET_DAC_SETTING_SIGN];
      s_next.source.offset_dac_setting_magnitude = s_next.offset_dac_setting[6:0];


      // R11 - reference controls
      s_next.ref_on = s_next.setup[SETUP_REF_EN];
      s_next.ref_high = s_next.setup[SETUP_HIGH_REFERENCE_SELECT];
   end

   // ==========================================================
   // state register
   // reset loads register defaults; routing
   // outputs mirror the selector reset value
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.setup <= SETUP_RESET;
         s_reg.mux <= MUX_RESET;
         s_reg.analog_control_register <= ZERO_RESET;
         s_reg.offset_dac_setting <= ZERO_RESET;
         s_reg.pin_level_register <= ZERO_RESET;
         // R19 - pins start as inputs
         s_reg.pin_output_select <= DIR_RESET;
         s_reg.rate_divider_low <= RATE_DIVIDER_LOW_RESET;
         s_reg.filter_mode_rate_high <= MDEC1_RESET;
         s_reg.phase <= PH_RUN;
         s_reg.ready_n <= 1'b1;
         s_reg.auto_stage <= FILT_FAST;
         s_reg.filter <= FILT_FAST;
         s_reg.route.ext_connect <= 1'b1;
         s_reg.route.neg_sel <= MUX_RESET[3:0];
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs, all from flops
   // each output but cal_busy is a plain copy of a state flop
   // R20 - direction and level
   assign dio_oe = s_reg.pin_output_select;
   assign dio_out = s_reg.pin_level_register;
   assign reg_rdata = s_reg.rdata;
   assign conversion_ready_flag_n = s_reg.ready_n;
   assign cal_busy = (s_reg.phase == PH_CAL);
   assign mod_clk = s_reg.mod_clk;
   assign conv_strobe = s_reg.strobe;
   assign filter_sel = s_reg.filter;
   assign route = s_reg.route;
   assign source = s_reg.source;
   assign ref_on = s_reg.ref_on;
   assign high_reference_select = s_reg.ref_high;

endmodule
`default_nettype wire

// >>> adc_cfg_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker
module adc_cfg_monitor
   import adc_cfg_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       cal_start,
   input wire logic       data_read,
   input wire logic [7:0] dio_in,
   input wire logic [7:0] dio_out,
   input wire logic [7:0] dio_oe,
   input wire logic       conversion_ready_flag_n,
   input wire logic       cal_busy,
   input wire logic       mod_clk,
   input wire logic       conv_strobe,
   input wire route_t     route,
   input wire source_t    source
);
   logic       mod_prev;
   logic [8:0] mod_cnt;
   logic [1:0] mod_seen;
   logic [7:0] wd_q;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_wr(logic [3:0] a);
      reg_wr && reg_addr == a;
   endsequence
   // modulator period count, restarted by each rise; rise count restarted by setup writes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mod_prev <= 1'b0;
         mod_cnt  <= 9'h000;
         mod_seen <= 2'h0;
         wd_q     <= 8'h00;
      end else begin
         mod_prev <= mod_clk;
         wd_q     <= reg_wdata;
         mod_cnt  <= (mod_clk && !mod_prev) ? 9'h000 : mod_cnt + 9'h001;
         if (reg_wr && reg_addr == ADDR_SETUP)
            mod_seen <= 2'h0;
         else if (mod_clk && !mod_prev && mod_seen != 2'h3)
            mod_seen <= mod_seen + 2'h1;
      end
   end
   a_diode_route : assert property (
      s_wr(ADDR_MUX) ##0 reg_wdata == MUX_TEMP_DIODE |=> route.diode_connect
      && !route.ext_connect && route.first_current_source_to_diode)
      else $error("diode routing wrong");
   a_mux_route : assert property (
      s_wr(ADDR_MUX) ##0 reg_wdata != MUX_TEMP_DIODE |=> route.ext_connect
      && !route.diode_connect && {route.pos_sel, route.neg_sel} == wd_q)
      else $error("channel routing wrong");
   a_acr_fields : assert property (
      s_wr(ADDR_ACR) |=> route.burnout_source == wd_q[ACR_BOCS]
      && route.burnout_sink == wd_q[ACR_BOCS]
      && {source.second_current_source_range, source.first_current_source_range, source.gain_code}
      == wd_q[6:0])
      else $error("analog control fields wrong");
   a_offset_dac_setting_fields : assert property (
      s_wr(ADDR_OFFSET_DAC_SETTING) |=> {source.offset_dac_setting_negative, source.offset_dac_setting_magnitude} == wd_q)
      else $error("offset setting wrong");
   a_dir_follow : assert property (
      s_wr(ADDR_DIR) |=> dio_oe == wd_q)
      else $error("pin direction wrong");
   a_pin_read : assert property (
      reg_rd && reg_addr == ADDR_DIO |=> reg_rdata == (($past(dio_out)
      & $past(dio_oe)) | ($past(dio_in) & ~$past(dio_oe))))
      else $error("pin read wrong");
   a_cal_begin : assert property (
      cal_start |=> cal_busy && conversion_ready_flag_n)
      else $error("calibration start wrong");
   a_cal_done : assert property (
      $fell(cal_busy) |-> !conversion_ready_flag_n)
      else $error("ready not low after calibration");
   a_ready_clear : assert property (
      data_read && !cal_start ##1 !conv_strobe && !$fell(cal_busy)
      |-> conversion_ready_flag_n)
      else $error("ready not cleared by read");
   a_strobe_low : assert property (
      conv_strobe |-> !conversion_ready_flag_n)
      else $error("ready not low with result");
   a_mod_period : assert property (
      mod_clk && !mod_prev && mod_seen == 2'h3
      |-> mod_cnt == 9'h07f || mod_cnt == 9'h0ff)
      else $error("modulator period wrong");
endmodule
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host side register driver
module host_model
   import adc_cfg_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd,
   output var  logic [3:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       cal_start,
   output var  cal_kind_t  cal_kind,
   output var  logic       data_read
);
   // idle bus at time zero
   initial begin
      {reg_wr, reg_rd, cal_start, data_read} = 4'h0;
      reg_addr  = 4'h0;
      reg_wdata = 8'h00;
      cal_kind  = CAL_SELF_OFS;
   end
   // byte write, data flipped once released
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask
   // byte read, data taken after answer edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      d        = reg_rdata;
   endtask
   task automatic cal(input cal_kind_t k);
      @(negedge ref_clk);
      cal_kind  = k;
      cal_start = 1'b1;
      @(negedge ref_clk);
      cal_start = 1'b0;
   endtask
   // result taken by host
   task automatic ack();
      @(negedge ref_clk);
      data_read = 1'b1;
      @(negedge ref_clk);
      data_read = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// top of bench
module testbench;
   import adc_cfg_pkg::*;
   logic       ref_clk, rst, buffer_enable_pin, reg_wr, reg_rd;
   logic       cal_start, data_read, conversion_ready_flag_n, cal_busy;
   logic       mod_clk, conv_strobe, ref_on, high_reference_select;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, dio_in, dio_out, dio_oe, rv;
   cal_kind_t  cal_kind;
   filter_t    filter_sel;
   route_t     route;
   source_t    source;
   int         fails = 0, compares = 0, cyc = 0, n, e;
   filter_t    fx[3] = '{FILT_FAST, FILT_SINC2, FILT_SINC3};
   adc_channel_config_control dut (.ref_clk, .rst, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .cal_start, .cal_kind, .data_read,
      .buffer_enable_pin, .dio_in, .dio_out, .dio_oe, .conversion_ready_flag_n,
      .cal_busy, .mod_clk, .conv_strobe, .filter_sel, .route, .source,
      .ref_on, .high_reference_select);
   host_model host (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .cal_start, .cal_kind, .data_read);
   // clock and hang limit
   initial ref_clk = 1'b0;
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] x);
      compares++;
      if (s !== x) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // cycles from one modulator rise to the next, minus one
   task automatic rise(output int c);
      logic pv;
      c = 0;
      pv = mod_clk;
      @(negedge ref_clk);
      while (!(mod_clk === 1'b1 && pv === 1'b0) && c < 600) begin
         pv = mod_clk;
         @(negedge ref_clk);
         c++;
      end
   endtask
   task automatic wait_strobe();
      n = 0;
      while (conv_strobe !== 1'b1 && n < 4000) begin
         @(negedge ref_clk);
         n++;
      end
      chk(16'(n < 4000), 16'h0001);
   endtask
   // main sequence
   initial begin
      rst = 1'b1;
      buffer_enable_pin = 1'b0;
      dio_in = 8'h5a;
      repeat (10) @(negedge ref_clk);
      rst = 1'b0;
      chk(dio_oe, 8'h00);
      host.rd(ADDR_DIO, rv);
      chk(rv, 8'h5a);
      host.rd(ADDR_MUX, rv);
      chk(rv, MUX_RESET);
      host.wr(4'hc, 8'hff);
      host.rd(4'hc, rv);
      chk(rv, 8'h00);
      $display("test reset done");
      host.wr(ADDR_MUX, 8'h23);
      chk({route.pos_sel, route.neg_sel, route.ext_connect}, 9'h047);
      host.wr(ADDR_MUX, 8'hff);
      chk({route.diode_connect, route.ext_connect, route.first_current_source_to_diode},
          3'h5);
      host.wr(ADDR_ACR, 8'hb5);
      chk({route.burnout_source, route.burnout_sink}, 2'h3);
      chk({source.second_current_source_range, source.first_current_source_range}, 4'h6);
      host.wr(ADDR_FIRST_CURRENT_SOURCE, 8'h3c);
      host.wr(ADDR_SECOND_CURRENT_SOURCE, 8'hc3);
      chk({source.first_current_source_code, source.second_current_source_code}, 16'h3cc3);
      for (int g = 0; g < 8; g++) begin
         host.wr(ADDR_ACR, {5'h00, 3'(g)});
         chk({route.burnout_source, source.gain_code}, 4'(g));
      end
      host.wr(ADDR_OFFSET_DAC_SETTING, 8'h85);
      chk({source.offset_dac_setting_negative, source.offset_dac_setting_magnitude}, 8'h85);
      $display("test analog done");
      for (int i = 0; i < 4; i++) begin
         buffer_enable_pin = i[1];
         host.wr(ADDR_SETUP, {4'h0, 1'b1, i[0] ^ i[1], i[0], 1'b0});
         repeat (2) @(negedge ref_clk);
         chk(route.buffer_on, i[0] & i[1]);
         chk({ref_on, high_reference_select}, {1'b1, i[0] ^ i[1]});
      end
      host.wr(ADDR_SETUP, 8'h00);
      chk(ref_on, 1'b0);
      repeat (3) rise(n);
      chk(16'(n + 1), 16'h0080);
      host.wr(ADDR_SETUP, 8'h10);
      repeat (3) rise(n);
      chk(16'(n + 1), 16'h0100);
      host.wr(ADDR_SETUP, 8'h00);
      $display("test setup done");
      host.wr(ADDR_DIR, 8'h0f);
      host.wr(ADDR_DIO, 8'ha5);
      dio_in = 8'h3c;
      chk({dio_oe, dio_out}, 16'h0fa5);
      host.rd(ADDR_DIO, rv);
      chk(rv, 8'h35);
      $display("test pins done");
      for (int m = 0; m < 3; m++) begin
         host.wr(ADDR_MDEC1, {2'h0, 2'(m + 1), 4'h0});
         chk(filter_sel, fx[m]);
      end
      host.wr(ADDR_RATE_DIVIDER_LOW, 8'h04);
      host.wr(ADDR_MDEC1, 8'h00);
      host.wr(ADDR_MUX, 8'h45);
      chk(filter_sel, FILT_FAST);
      for (int m = 1; m < 3; m++) begin
         wait_strobe();
         chk(conversion_ready_flag_n, 1'b0);
         repeat (2) @(negedge ref_clk);
         chk(filter_sel, fx[m]);
      end
      host.ack();
      chk(conversion_ready_flag_n, 1'b1);
      $display("test filter done");
      for (int k = 0; k < 5; k++) begin
         host.cal(cal_kind_t'(k));
         e = (k == 2) ? 14 * 512 : 7 * 512;
         n = 0;
         while (cal_busy === 1'b1 && n < 9000) begin
            @(negedge ref_clk);
            n++;
         end
         chk(16'(n > e - 512 && n <= e + 2), 16'h0001);
         chk(conversion_ready_flag_n, 1'b0);
         host.ack();
      end
      $display("test calibration done");
      host.wr(ADDR_DIR, 8'hff);
      chk(dio_oe, 8'hff);
      print_verdict();
   end
endmodule
bind adc_channel_config_control adc_cfg_monitor mon (.ref_clk, .rst,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .cal_start,
   .data_read, .dio_in, .dio_out, .dio_oe, .conversion_ready_flag_n,
   .cal_busy, .mod_clk, .conv_strobe, .route, .source);
`default_nettype wire
